/* core/ebtg_core.sv */
/*
  ebtg_core: per-stream bert traffic generator and receive checker with APB registers.
  assumes frame_ready_in from the mac accepts one byte per cycle, and rx event
  strobes arrive one cycle wide and synchronous to clock_in.
*/
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ebtg_core #(
  parameter int unsigned MS_DIV  = ebtg_pkg::MS_CYCLES,
  parameter int unsigned SEC_DIV = ebtg_pkg::SEC_CYCLES
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        meas_run_in,
  input  wire logic        frame_ready_in,
  output logic             frame_valid_out,
  output logic             frame_sop_out,
  output logic [13:0]      frame_len_out,
  output logic             frame_gap_out,
  input  wire logic        rx_lost_in,
  input  wire logic [15:0] rx_lost_bits_in,
  input  wire logic        rx_bit_err_in,
  input  wire logic        rx_match_in,
  input  wire logic        rx_loss_sec_in,
  output logic             stats_valid_out,
  output logic             capture_valid_out,
  output logic             ber_alarm_out,
  output logic             status_fail_out,
  output logic             irq_out
);
  import ebtg_pkg::*;

  typedef struct packed {
    logic [31:0]  ctrl;
    logic [31:0]  fsize;     // [13:0] start, [29:16] end
    logic [31:0]  fstep;     // [13:0] step, [31:16] hold seconds
    logic [31:0]  load;      // [7:0] start ifg, [15:8] end ifg
    logic [31:0]  ramp;      // [7:0] step bytes, [31:16] step duration
    logic [31:0]  dur;       // seconds or frames
    logic [IRQ_W-1:0] irq;
    logic [IRQ_W-1:0] mask;
    logic [31:0]  txcnt;
    logic [31:0]  errcnt;
    logic [31:0]  seccnt;
    logic [15:0]  hold;      // seconds in current frame size
    logic [15:0]  rhold;     // ticks in current ramp step
    logic [13:0]  cur_size;
    logic [13:0]  flen;      // size latched at frame start, so a step never cuts a frame
    logic [7:0]   cur_ifg;
    logic         rdir;      // 1 = walking back toward start
    logic         ramp_done;
    logic         active;
    logic         done;
    ebtg_tx_t     tx;
    logic [13:0]  bcnt;
    logic [15:0]  lfsr;
    logic [31:0]  rdata;
    logic         ber;
    logic         fail;
    logic         stats;
    logic         capt;
  } ebtg_st_t;

  ebtg_st_t s;
  ebtg_st_t next_s;
  ebtg_tick_if tk ();

  // size clipped into the start..end window by modulo
  function automatic logic [13:0] clip_size(input logic [15:0] r, input logic [13:0] lo, input logic [13:0] hi);
    logic [13:0] span;
    span = hi - lo + 14'h0001;
    clip_size = (hi <= lo) ? lo : lo + 14'(r[13:0] % span);
  endfunction : clip_size

  // ==========================================================================
  // field views
  logic        en, auto_st, rate_ok, ramp_en, ms_ramp;
  logic [13:0] fs_lo, fs_hi, fs_step;
  logic [7:0]  ld_lo, ld_hi, rs;
  ebtg_fsmode_t fsm;
  ebtg_dur_t    dm;
  ebtg_rmode_t  rm;
  logic        apb_wr, apb_rd, rtick;
  assign en      = s.ctrl[C_EN];
  assign auto_st = s.ctrl[C_AUTO];
  assign rate_ok = s.ctrl[C_RATE_OK];
  assign ramp_en = s.ctrl[C_RAMP];
  assign ms_ramp = s.ctrl[C_MSRAMP] & rate_ok;
  assign fsm     = ebtg_fsmode_t'(s.ctrl[FSM_LSB +: 2]);
  assign dm      = ebtg_dur_t'(s.ctrl[DUR_LSB +: 2]);
  assign rm      = ebtg_rmode_t'(s.ctrl[RMODE_LSB +: 2]);
  assign fs_lo   = s.fsize[13:0];
  assign fs_hi   = s.fsize[29:16];
  assign fs_step = s.fstep[13:0];
  assign ld_lo   = s.load[7:0];
  assign ld_hi   = s.load[15:8];
  assign rs      = s.ramp[7:0];
  assign apb_wr  = psel_in & penable_in & pwrite_in;
  assign apb_rd  = psel_in & ~penable_in & ~pwrite_in;
  assign rtick   = ms_ramp ? tk.ms_tick : tk.sec_tick;

  ebtg_tick #(
    .MS_DIV  (MS_DIV),
    .SEC_DIV (SEC_DIV)
  ) u_tick (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .run_in   (s.active),
    .tick     (tk.src)
  );

  // ==========================================================================
  // next state
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic             eof;
    logic             start;
    ev    = '0;
    next_s = s;
    eof   = 1'b0;
    // start: auto start follows the measurement only in continuous mode
    start = en & ~s.active & ~s.done & (~(auto_st && dm == DUR_CONT) | meas_run_in);
    if (!en) begin
      next_s.active = 1'b0;
      next_s.done   = 1'b0;
      next_s.tx     = ST_IDLE;
    end else if (start) begin
      next_s.active   = 1'b1;
      next_s.txcnt    = '0;
      next_s.seccnt   = '0;
      next_s.hold     = '0;
      next_s.rhold    = '0;
      next_s.rdir     = 1'b0;
      next_s.ramp_done = 1'b0;
      next_s.cur_size = fs_lo;
      next_s.cur_ifg  = ramp_en ? ld_lo : ld_hi;
    end
    // transmit sequencer: frame bytes then average gap (ifg plus preamble)
    unique case (s.tx)
      ST_IDLE: begin
        if (s.active && en) begin
          next_s.tx   = ST_FRAME;
          next_s.bcnt = '0;
          next_s.flen = (fsm == FS_RAND) ? clip_size(s.lfsr, fs_lo, fs_hi) : s.cur_size;
          if (fsm == FS_RAND) next_s.cur_size = clip_size(s.lfsr, fs_lo, fs_hi);
        end
      end
      ST_FRAME: begin
        // only bytes really offered count; burst or off holds the frame back
        if (frame_ready_in && frame_valid_out) begin
          next_s.bcnt = s.bcnt + 14'h0001;
          if (s.bcnt == s.flen - 14'h0001) begin
            eof         = 1'b1;
            next_s.tx   = ST_GAP;
            next_s.bcnt = '0;
          end
        end
      end
      ST_GAP: begin
        // a 12 byte gap gives full load; lower settings below 12 allow slight overload
        next_s.bcnt = s.bcnt + 14'h0001;
        if (s.bcnt >= {6'h00, s.cur_ifg} + {6'h00, PREAMBLE_BYTES} - 14'h0001) begin
          next_s.tx = (s.active && en) ? ST_FRAME : ST_IDLE;
          next_s.bcnt = '0;
          next_s.flen = (fsm == FS_RAND) ? clip_size(s.lfsr, fs_lo, fs_hi) : s.cur_size;
          if (fsm == FS_RAND) next_s.cur_size = clip_size(s.lfsr, fs_lo, fs_hi);
        end
      end
    endcase
    if (eof) next_s.txcnt = s.txcnt + 32'h0000_0001;
    // frame-count duration
    if (s.active && dm == DUR_FRM && next_s.txcnt >= s.dur) begin
      next_s.active = 1'b0;
      next_s.done   = 1'b1;
      ev[I_DONE]    = 1'b1;
    end
    // seconds: duration and stepped frame size
    if (s.active && tk.sec_tick) begin
      next_s.seccnt = s.seccnt + 32'h0000_0001;
      if (dm == DUR_SEC && s.seccnt + 32'h0000_0001 >= s.dur) begin
        next_s.active = 1'b0;
        next_s.done   = 1'b1;
        ev[I_DONE]    = 1'b1;
      end
      if (fsm == FS_STEP) begin
        next_s.hold = s.hold + 16'h0001;
        if (s.hold + 16'h0001 >= s.fstep[31:16]) begin
          next_s.hold = '0;
          if (s.cur_size + fs_step <= fs_hi && fs_step != '0) next_s.cur_size = s.cur_size + fs_step;
          else next_s.cur_size = fs_lo;
        end
      end
    end
    // line load ramp on gap values
    if (s.active && ramp_en && rtick && !s.ramp_done) begin
      next_s.rhold = s.rhold + 16'h0001;
      if (s.rhold + 16'h0001 >= s.ramp[31:16]) begin
        next_s.rhold = '0;
        if (!s.rdir) begin
          if (s.cur_ifg == ld_hi || rs == '0) begin
            unique case (rm)
              RM_REPEAT: next_s.cur_ifg = ld_lo;
              RM_INVERT: next_s.rdir = 1'b1;
              default:   next_s.ramp_done = 1'b1;
            endcase
          end else if (ld_hi > ld_lo) begin
            next_s.cur_ifg = (ld_hi - s.cur_ifg > rs) ? s.cur_ifg + rs : ld_hi;
          end else begin
            next_s.cur_ifg = (s.cur_ifg - ld_hi > rs) ? s.cur_ifg - rs : ld_hi;
          end
        end else begin
          if (s.cur_ifg == ld_lo) next_s.rdir = 1'b0;
          else if (ld_lo > ld_hi) next_s.cur_ifg = (ld_lo - s.cur_ifg > rs) ? s.cur_ifg + rs : ld_lo;
          else next_s.cur_ifg = (s.cur_ifg - ld_lo > rs) ? s.cur_ifg - rs : ld_lo;
        end
      end
    end
    // receive checker
    if (rx_lost_in && s.ctrl[C_LOSTERR]) next_s.errcnt = s.errcnt + {16'h0000, rx_lost_bits_in};
    else if (rx_bit_err_in) next_s.errcnt = s.errcnt + 32'h0000_0001;
    next_s.stats = rx_match_in | ~s.ctrl[C_FILT];
    next_s.capt  = 1'b1;
    next_s.ber   = (rx_bit_err_in | (rx_lost_in & s.ctrl[C_LOSTERR])) & (meas_run_in | ~s.ctrl[C_GATE]);
    next_s.fail  = rx_bit_err_in | (rx_loss_sec_in & ~s.ctrl[C_IGNLOSS]);
    ev[I_BER]  = next_s.ber;
    ev[I_FAIL] = next_s.fail;
    next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
    // registers; burst and ms ramp bits stick only at 100 Gbps or below
    next_s.rdata = '0;
    if (apb_rd) begin
      unique case (paddr_in)
        A_CTRL:   next_s.rdata = s.ctrl;
        A_FSIZE:  next_s.rdata = s.fsize;
        A_FSTEP:  next_s.rdata = s.fstep;
        A_LOAD:   next_s.rdata = s.load;
        A_RAMP:   next_s.rdata = s.ramp;
        A_DUR:    next_s.rdata = s.dur;
        A_STATUS: next_s.rdata = {16'h0000, s.cur_size[13:0], s.active, s.done};
        A_IRQ:    next_s.rdata = {29'h0000_0000, s.irq};
        A_MASK:   next_s.rdata = {29'h0000_0000, s.mask};
        A_TXCNT:  next_s.rdata = s.txcnt;
        A_ERRCNT: next_s.rdata = s.errcnt;
        A_FILTER: next_s.rdata = {24'h0000_00, s.cur_ifg};
        default:  next_s.rdata = '0;
      endcase
    end
    next_s.irq = s.irq;
    if (apb_wr) begin
      unique case (paddr_in)
        A_CTRL: begin
          next_s.ctrl = pwdata_in;
          next_s.ctrl[C_BURST]  = pwdata_in[C_BURST] & pwdata_in[C_RATE_OK];
          next_s.ctrl[C_MSRAMP] = pwdata_in[C_MSRAMP] & pwdata_in[C_RATE_OK];
        end
        A_FSIZE: next_s.fsize = pwdata_in;
        A_FSTEP: next_s.fstep = pwdata_in;
        A_LOAD:  next_s.load  = pwdata_in;
        A_RAMP:  next_s.ramp  = pwdata_in;
        A_DUR:   next_s.dur   = pwdata_in;
        A_IRQ:   next_s.irq   = s.irq & ~pwdata_in[IRQ_W-1:0];
        A_MASK:  next_s.mask  = pwdata_in[IRQ_W-1:0];
        default: next_s.irq   = s.irq;
      endcase
    end
    next_s.irq = next_s.irq | ev;                               // set beats clear
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s      <= '0;
      s.lfsr <= 16'hACE1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs; burst frames are not produced here, burst bit gates normal traffic off
  assign prdata_out        = s.rdata;
  assign pready_out        = 1'b1;
  assign pslverr_out       = 1'b0;
  assign frame_valid_out   = (s.tx == ST_FRAME) & en & ~s.ctrl[C_BURST];
  assign frame_sop_out     = frame_valid_out & (s.bcnt == '0);
  assign frame_len_out     = s.flen;
  assign frame_gap_out     = (s.tx == ST_GAP);
  assign stats_valid_out   = s.stats;
  assign capture_valid_out = s.capt;
  assign ber_alarm_out     = s.ber;
  assign status_fail_out   = s.fail;
  assign irq_out           = |(s.irq & s.mask);
endmodule : ebtg_core

/* core/ebtg_tick.sv */
/*
  ebtg_tick: millisecond and second strobes from the system clock.
  assumes clock_in at the package rate; counters restart while run is low.
*/
`timescale 1ns/1ps
module ebtg_tick #(
  parameter int unsigned MS_DIV  = ebtg_pkg::MS_CYCLES,
  parameter int unsigned SEC_DIV = ebtg_pkg::SEC_CYCLES
) (
  input  wire logic   clock_in,
  input  wire logic   rst_n_in,
  input  wire logic   run_in,
  ebtg_tick_if.src    tick
);
  import ebtg_pkg::*;
  typedef struct packed {
    logic [31:0] ms_cnt;
    logic [31:0] sec_cnt;
    logic        ms;
    logic        sec;
  } ebtg_tick_st_t;
  ebtg_tick_st_t s;
  ebtg_tick_st_t next_s;

  // ==========================================================================
  // dividers; restarting on run keeps the first step a full interval
  always_comb begin
    next_s = s;
    next_s.ms  = 1'b0;
    next_s.sec = 1'b0;
    if (!run_in) begin
      next_s.ms_cnt  = '0;
      next_s.sec_cnt = '0;
    end else begin
      next_s.ms_cnt  = s.ms_cnt + 32'h0000_0001;
      next_s.sec_cnt = s.sec_cnt + 32'h0000_0001;
      if (s.ms_cnt == MS_DIV - 1) begin
        next_s.ms_cnt = '0;
        next_s.ms     = 1'b1;
      end
      if (s.sec_cnt == SEC_DIV - 1) begin
        next_s.sec_cnt = '0;
        next_s.sec     = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) s <= '0;
    else s <= next_s;
  end

  assign tick.ms_tick  = s.ms;
  assign tick.sec_tick = s.sec;
endmodule : ebtg_tick

/* inc/ebtg_pkg.sv */
/*
  ebtg_pkg: shared constants and types for the ethernet bert traffic generator.
  assumes a 100 MHz system clock and an APB register slave with 32-bit data.
*/
package ebtg_pkg;
  // ==========================================================================
  // timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned MS_TIME        = 1;                     // ms per ramp tick
  localparam int unsigned MS_CYCLES      = MS_TIME * CLK_MHZ * 1000;
  localparam int unsigned SEC_TIME       = 1;                     // s per second tick
  localparam int unsigned SEC_CYCLES     = SEC_TIME * CLK_MHZ * 1000000;
  localparam logic [7:0]  FULL_IFG       = 8'h0C;                 // 12 byte gap = full load
  localparam logic [7:0]  PREAMBLE_BYTES = 8'h08;
  // ==========================================================================
  // register offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_FSIZE   = 8'h04;
  localparam logic [7:0] A_FSTEP   = 8'h08;
  localparam logic [7:0] A_LOAD    = 8'h0C;
  localparam logic [7:0] A_RAMP    = 8'h10;
  localparam logic [7:0] A_DUR     = 8'h14;
  localparam logic [7:0] A_STATUS  = 8'h18;
  localparam logic [7:0] A_IRQ     = 8'h1C;
  localparam logic [7:0] A_MASK    = 8'h20;
  localparam logic [7:0] A_TXCNT   = 8'h24;
  localparam logic [7:0] A_ERRCNT  = 8'h28;
  localparam logic [7:0] A_FILTER  = 8'h2C;
  // ==========================================================================
  // ctrl fields
  localparam int C_EN = 0;    // stream enable
  localparam int C_AUTO = 1;  // auto start with measurement, continuous duration mode only
  localparam int C_LOSTERR = 2;
  localparam int C_FILT = 3;
  localparam int C_GATE = 4;
  localparam int C_IGNLOSS = 5;
  localparam int C_BURST = 6;
  localparam int C_RAMP = 7;
  localparam int C_MSRAMP = 8;
  localparam int C_RATE_OK = 9;  // port rate 100 Gbps or less
  localparam int FSM_LSB = 12;   // frame size mode [13:12]
  localparam int DUR_LSB = 14;   // duration mode [15:14]
  localparam int RMODE_LSB = 16; // ramp mode [17:16]
  // irq bits
  localparam int I_DONE = 0;
  localparam int I_BER  = 1;
  localparam int I_FAIL = 2;
  localparam int IRQ_W  = 3;

  typedef enum logic [1:0] {FS_CONST = 2'b00, FS_STEP = 2'b01, FS_RAND = 2'b10} ebtg_fsmode_t;
  typedef enum logic [1:0] {DUR_CONT = 2'b00, DUR_SEC = 2'b01, DUR_FRM = 2'b10} ebtg_dur_t;
  typedef enum logic [1:0] {RM_KEEP = 2'b00, RM_REPEAT = 2'b01, RM_INVERT = 2'b10} ebtg_rmode_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_FRAME = 2'b01, ST_GAP = 2'b11} ebtg_tx_t;
endpackage : ebtg_pkg

/* inc/ebtg_tick_if.sv */
/*
  ebtg_tick_if: carries the timebase ticks from the tick module to the core.
  assumes one clock domain.
*/
`timescale 1ns/1ps
interface ebtg_tick_if;
  logic ms_tick;
  logic sec_tick;
  modport src (output ms_tick, output sec_tick);
  modport dst (input ms_tick, input sec_tick);
endinterface : ebtg_tick_if

/* verification/ebtg_core_properties.sv */
/*
  ebtg_core_properties: port-level checks on the traffic generator core.
  assumes it is bound to ebtg_core; one clock, async active-low reset.
*/
`timescale 1ns/1ps
module ebtg_core_properties
  import ebtg_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        meas_run_in,
  input wire logic        rx_match_in,
  input wire logic        frame_valid_out,
  input wire logic        frame_sop_out,
  input wire logic [13:0] frame_len_out,
  input wire logic        frame_gap_out,
  input wire logic        stats_valid_out,
  input wire logic        capture_valid_out,
  input wire logic        ber_alarm_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================================
  // shadow of the control word, so rules can see the mode bits
  logic [31:0] ctrl_q;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) ctrl_q <= '0;
    else if (psel_in && penable_in && pwrite_in && paddr_in == A_CTRL) ctrl_q <= pwdata_in;
  end
  // ==========================================================================
  // assertions
  a_zero_wait: assert property (psel_in && penable_in |-> pready_out && !pslverr_out)
    else $error("apb access not completed at once");
  a_len_held: assert property (frame_valid_out && !frame_sop_out |-> $stable(frame_len_out))
    else $error("frame size moved inside a frame");
  a_gap_floor: assert property ($rose(frame_gap_out) |-> frame_gap_out [*8])
    else $error("gap shorter than preamble");
  a_gap_quiet: assert property (frame_gap_out |-> !frame_valid_out)
    else $error("bytes sent inside a gap");
  a_off_silent: assert property (!ctrl_q[C_EN] && !$past(ctrl_q[C_EN]) |-> !frame_sop_out)
    else $error("frame started while stream off");
  a_burst_quiet: assert property (ctrl_q[C_BURST] && $past(ctrl_q[C_BURST]) |-> !frame_sop_out)
    else $error("normal frame started in burst mode");
  a_auto_hold: assert property ($past(ctrl_q[C_AUTO] && ctrl_q[15:14] == 2'b00 && !meas_run_in
    && !frame_valid_out && !frame_gap_out) |-> !frame_sop_out)
    else $error("auto start ran ahead of measurement");
  a_gate_alarm: assert property (ctrl_q[C_GATE] && $past(ctrl_q[C_GATE] && !meas_run_in) |-> !ber_alarm_out)
    else $error("ber alarm while not measuring");
  a_filter_stats: assert property ($past(ctrl_q[C_FILT] && !rx_match_in) |-> !stats_valid_out)
    else $error("filtered frame reached statistics");
  a_capture_free: assert property ($past(rst_n_in) |-> capture_valid_out)
    else $error("capture path blocked");
  // ==========================================================================
  // coverage of the main scenarios
  c_frame_sent: cover property (frame_sop_out && frame_valid_out);
  c_gap_done: cover property ($fell(frame_gap_out));
  c_filter_drop: cover property (ctrl_q[C_FILT] && !stats_valid_out);
endmodule : ebtg_core_properties

bind ebtg_core ebtg_core_properties ebtg_core_properties_i (.clock_in, .rst_n_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .meas_run_in, .rx_match_in,
  .frame_valid_out, .frame_sop_out, .frame_len_out, .frame_gap_out, .stats_valid_out,
  .capture_valid_out, .ber_alarm_out);

/* verification/ebtg_core_tb.sv */
/*
  ebtg_core_tb: self-checking bench for the traffic generator core.
  assumes short tick dividers (10 / 100 cycles) and the net model as sink.
*/
`timescale 1ns/1ps
module ebtg_core_tb;
  import ebtg_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} ebtg_row_t;
  logic clock_in, rst_n_in, psel, penable, pwrite, pready, pslverr, meas, ready, stall;
  logic valid, sop, gap, lost, berr, match, lsec, stats, capt, alarm, fail, irq, gp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [13:0] len;
  logic [15:0] lbits;
  int fail_count = 0, n_tests = 0, nb = 0, gcnt = 0, gap_len = 0, nsop = 0, cyc = 0, k;
  int sizes[$], q[$];
  ebtg_row_t rows[7] = '{'{A_FSIZE, 32'h0100_0040, 32'h0100_0040}, '{A_FSTEP, 32'h0002_0004, 32'h0002_0004},
    '{A_LOAD, 32'h0000_0C20, 32'h0000_0C20}, '{A_RAMP, 32'h0005_0002, 32'h0005_0002},
    '{A_DUR, 32'h0000_0010, 32'h0000_0010}, '{A_MASK, 32'h0000_0007, 32'h0000_0007},
    '{8'h30, 32'hFFFF_FFFF, 32'h0000_0000}};

  ebtg_core #(.MS_DIV(10), .SEC_DIV(100)) ebtg_core_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .meas_run_in(meas),
    .frame_ready_in(ready), .frame_valid_out(valid), .frame_sop_out(sop), .frame_len_out(len),
    .frame_gap_out(gap), .rx_lost_in(lost), .rx_lost_bits_in(lbits), .rx_bit_err_in(berr),
    .rx_match_in(match), .rx_loss_sec_in(lsec), .stats_valid_out(stats), .capture_valid_out(capt),
    .ber_alarm_out(alarm), .status_fail_out(fail), .irq_out(irq));
  ebtg_net_model ebtg_net_model_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .stall_in(stall),
    .frame_valid_in(valid), .frame_ready_out(ready));

  // ==========================================================================
  // clock and hang guard; the whole run needs well under 20000 cycles
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out;
    end
  end
  // bytes per frame, frame starts and gap length as seen by the sink
  always @(posedge clock_in) begin
    if (valid && ready) nb = sop ? 1 : nb + 1;
    if (valid && ready && sop) nsop++;
    if (gap && !gp) sizes.push_back(nb);
    if (gap) gcnt = gp ? gcnt + 1 : 1;
    else if (gp) gap_len = gcnt;
    gp = gap;
  end
  // ==========================================================================
  // tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one apb transfer; the request stands until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock_in);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
  task rd(input logic [7:0] a); apb(1'b0, a, 32'h0000_0000); endtask : rd
  task cw(input int n); repeat (n) @(posedge clock_in); endtask : cw
  task wait_irq;
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clock_in);
    chk(irq, 1);
  endtask : wait_irq
  // one-cycle receive event: {loss second, bit error, lost frame}; returns while the registered reply stands
  task ev(input logic [2:0] m);
    {lsec, berr, lost} <= m;
    @(posedge clock_in);
    {lsec, berr, lost} <= 3'b000;
    @(posedge clock_in);
  endtask : ev
  task uniq;
    q.delete();
    foreach (sizes[i]) if (q.size() == 0 || q[$] != sizes[i]) q.push_back(sizes[i]);
  endtask : uniq
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // ==========================================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, meas, stall, lost, berr, match, lsec, rst_n_in} <= '0;
    paddr <= 8'h00; pwdata <= 32'h0000_0000; lbits <= 16'h0000;
    cw(6);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    rd(A_CTRL); chk(r, 0);
    rd(A_IRQ); chk(r, 0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d); rd(rows[i].a); chk(r, rows[i].e);
    end
    // constant size, frame count, slow sink, then the interrupt
    wr(A_FSIZE, 32'h0040_0040); wr(A_LOAD, 32'h0000_0C0C); wr(A_DUR, 3); wr(A_MASK, 1);
    stall <= 1'b1; sizes.delete();
    wr(A_CTRL, 32'h0000_8001); wait_irq; cw(100);
    chk(sizes.size(), 3);
    foreach (sizes[i]) chk(sizes[i], 64);
    chk(len, 64);
    chk(gap_len, FULL_IFG + PREAMBLE_BYTES);
    rd(A_TXCNT); chk(r, 3);
    wr(A_MASK, 0); chk(irq, 0);
    wr(A_MASK, 1); chk(irq, 1);
    wr(A_IRQ, 1); chk(irq, 0);
    // stepped sizes: timed run stops, continuous run wraps
    wr(A_CTRL, 0); stall <= 1'b0;
    wr(A_FSIZE, 32'h0042_0040); wr(A_FSTEP, 32'h0001_0001); sizes.delete();
    wr(A_CTRL, 32'h0000_5001); wait_irq; wr(A_IRQ, 1); cw(40); uniq;
    chk(q.size(), 3); chk(q[0], 64); chk(q[1], 65); chk(q[2], 66);
    k = nsop; cw(200); chk(nsop, k);
    wr(A_CTRL, 0); sizes.delete();
    wr(A_CTRL, 32'h0000_1001); cw(900); uniq;
    chk(q[3], 64);
    // random sizes stay inside the window and vary
    wr(A_FSIZE, 32'h0048_0040); wr(A_CTRL, 0); sizes.delete();
    wr(A_CTRL, 32'h0000_2001); cw(1500); uniq;
    foreach (sizes[i]) chk(sizes[i] >= 64 && sizes[i] <= 72, 1);
    chk(q.size() > 3, 1);
    // stream off, burst mode and auto start hold back frames
    wr(A_CTRL, 0); cw(150); k = nsop; cw(300); chk(nsop, k);
    wr(A_CTRL, 32'h0000_0241); cw(200); chk(nsop, k);
    wr(A_CTRL, 0); wr(A_CTRL, 32'h0000_0003); cw(200); chk(nsop, k);
    meas <= 1'b1; cw(50); chk(nsop > k, 1);
    // millisecond ramp of the gap, 20 down to 12 in steps of 4, each mode
    for (int m = 0; m < 3; m++) begin
      wr(A_CTRL, 0); wr(A_LOAD, 32'h0000_0C14); wr(A_RAMP, 32'h0001_0004); q.delete();
      wr(A_CTRL, 32'h0000_0381 | (m << 16));
      repeat (60) begin
        rd(A_FILTER);
        if (q.size() == 0 || q[$] != r) q.push_back(r);
      end
      chk(q[0], 20); chk(q[1], 16); chk(q[2], 12);
      chk(m == 0 ? q.size() : q[3], m == 0 ? 3 : (m == 1 ? 20 : 16));
    end
    // lost frames feed the error counter only when enabled
    wr(A_CTRL, 0); rd(A_ERRCNT); k = r;
    wr(A_CTRL, 32'h0000_0004); lbits <= 16'h0100; ev(3'b001);
    rd(A_ERRCNT); chk(r, k + 256);
    wr(A_CTRL, 0); ev(3'b001);
    rd(A_ERRCNT); chk(r, k + 256);
    // loss seconds, filter and alarm gating
    wr(A_CTRL, 32'h0000_0020); ev(3'b100); chk(fail, 0);
    wr(A_CTRL, 0); ev(3'b100); chk(fail, 1);
    meas <= 1'b0;
    wr(A_CTRL, 32'h0000_0018); ev(3'b010);
    chk(stats, 0); chk(capt, 1); chk(alarm, 0);
    match <= 1'b1; cw(2); chk(stats, 1);
    wr(A_CTRL, 32'h0000_0010); meas <= 1'b1; ev(3'b010); chk(alarm, 1);
    close_out;
  end
endmodule : ebtg_core_tb

/* verification/ebtg_net_model.sv */
/*
  ebtg_net_model: byte sink standing for the network under test.
  assumes the bench asks for stalls through stall_in.
*/
`timescale 1ns/1ps
module ebtg_net_model (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic stall_in,
  input  wire logic frame_valid_in,
  output logic      frame_ready_out
);
  logic [1:0] phase;
  // ==========================================================================
  // free phase counter; a slow sink refuses every fourth byte slot
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) phase <= 2'b00;
    else phase <= phase + 2'b01;
  end
  assign frame_ready_out = !stall_in || (phase != 2'b11);
endmodule : ebtg_net_model
